// file: sim/lane_66b_block_framer_crc12_test.sv
`timescale 1ns/10ps
module lane_66b_block_framer_crc12_test;
    logic        core_clk_in = 1'b0;
    logic        srst_in     = 1'b1;
    logic        sysref_in   = 1'b0;
    logic        data_vld_in = 1'b1;
    logic        flip_bit    = 1'b0;
    logic        corrupt_hdr = 1'b0;
    logic        v1          = 1'b1;
    logic [63:0] data_in     = 64'h0011_2233_4455_6677;
    logic [63:0] d1, d2, rx_data;
    logic [4:0]  b1;
    logic        run, emb, undr, slip, rx_vld, rl, hdr_e, pl_e, crc_e;
    logic        bhdr_e, bcrc_e;
    int          num_errors = 0, n_compared = 0, cyc = 0, n_bhdr = 0;
    int          n_bcrc = 0;
    lbf_link_if link ();
    lbf_link_if bad_if ();
    // Second link breaks the header and payload on purpose
    assign bad_if.blk = {link.blk[65:3], link.blk[2] ^ flip_bit,
                         corrupt_hdr ? 2'b11 : link.blk[1:0]};
    assign bad_if.vld = link.vld;
    always #5 core_clk_in = ~core_clk_in;
    lbf_tx_framer u_lbf_tx_framer (.core_clk_in, .srst_in, .sysref_in,
        .data_in, .data_vld_in, .run_out(run), .emb_clk_out(emb),
        .underrun_out(undr), .sysref_slip_out(slip), .link(link));
    lbf_rx_deframer u_lbf_rx_deframer (.core_clk_in, .srst_in, .sysref_in,
        .link(link), .data_out(rx_data), .data_vld_out(rx_vld),
        .emb_clk_out(rl), .hdr_err_out(hdr_e), .pilot_err_out(pl_e),
        .crc_err_out(crc_e));
    lbf_rx_deframer u_lbf_rx_deframer_bad (.core_clk_in, .srst_in,
        .sysref_in, .link(bad_if), .data_out(), .data_vld_out(),
        .emb_clk_out(), .hdr_err_out(bhdr_e), .pilot_err_out(),
        .crc_err_out(bcrc_e));
    lbf_props u_lbf_props (.core_clk_in, .srst_in, .blk(link.blk),
        .vld(link.vld));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic pulse_sysref;
        @(negedge core_clk_in);
        sysref_in = 1'b1;
        @(negedge core_clk_in);
        sysref_in = 1'b0;
    endtask
    task automatic wait_idx(input logic [4:0] k);
        repeat (40) begin
            @(negedge core_clk_in);
            if (link.vld && u_lbf_props.cnt_r == k) begin
                return;
            end
        end
        num_errors++;
    endtask
    // Payload taken at each edge shows on the link until the next one
    always @(posedge core_clk_in) begin
        d2 <= d1;
        d1 <= data_vld_in ? data_in : 64'h0;
        v1 <= data_vld_in;
    end
    always @(negedge core_clk_in) begin
        cyc++;
        if (cyc > 1000) begin
            num_errors++;
            test_done();
        end
        if (!srst_in) begin
            if (link.vld) begin
                chk(link.blk[65:2], d1);
            end
            if (rx_vld) begin
                chk(rx_data, d2);
            end
            chk(emb, link.vld && u_lbf_props.cnt_r == 5'h00);
            chk(undr, link.vld && !v1);
            chk(rl, rx_vld && b1 == 5'h00);
            chk({hdr_e, pl_e, crc_e}, 3'h0);
            n_bhdr += bhdr_e;
            n_bcrc += bcrc_e;
            b1 = u_lbf_props.cnt_r;
            data_in = data_in + 64'h0123_4567_89AB_CDEF;
        end
    end
    initial begin
        repeat (3) @(negedge core_clk_in);
        srst_in = 1'b0;
        @(negedge core_clk_in);
        chk({run, link.vld}, 2'h0);
        pulse_sysref();
        chk({run, link.vld, slip}, 3'h4);
        repeat (100) @(negedge core_clk_in);
        wait_idx(5'h1D);
        pulse_sysref();
        chk({link.vld, slip}, 2'h2);
        wait_idx(5'h09);
        pulse_sysref();
        chk({link.vld, slip}, 2'h1);
        repeat (40) @(negedge core_clk_in);
        data_vld_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        data_vld_in = 1'b1;
        wait_idx(5'h04);
        flip_bit = 1'b1;
        @(negedge core_clk_in);
        flip_bit = 1'b0;
        wait_idx(5'h14);
        corrupt_hdr = 1'b1;
        @(negedge core_clk_in);
        corrupt_hdr = 1'b0;
        repeat (70) @(negedge core_clk_in);
        chk(n_bhdr, 1);
        chk(n_bcrc, 1);
        test_done();
    end
endmodule

// file: sim/lbf_props.sv
`timescale 1ns/10ps
module lbf_props (
    input wire logic                      core_clk_in,
    input wire logic                      srst_in,
    input wire logic [lbf_pkg::BLK_W-1:0] blk,
    input wire logic                      vld
);
    // Own serial parity, payload bit 0 first, so no design code is reused
    function automatic logic [11:0] crc_f(logic [11:0] c, logic [63:0] d);
        for (int i = 0; i < 64; i++) begin
            c = {c[10:0], 1'b0} ^ ((c[11] ^ d[i]) ? 12'h30F : 12'h000);
        end
        return c;
    endfunction
    logic [4:0]  cnt_r;
    logic [31:0] hs_r;
    logic [11:0] crc_r;
    logic [11:0] prv_r;
    logic [11:0] crc_nxt;
    logic [11:0] got_crc;
    assign crc_nxt = crc_f(crc_r, blk[65:2]);
    assign got_crc = {hs_r[0], hs_r[1], hs_r[2], hs_r[4], hs_r[5], hs_r[6],
                      hs_r[8], hs_r[9], hs_r[10], hs_r[12], hs_r[13], hs_r[14]};
    // A restart gap drops the parity history: first multiblock carries zero
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !vld) begin
            cnt_r <= 5'h00;
            crc_r <= 12'h000;
            prv_r <= 12'h000;
        end else begin
            cnt_r       <= cnt_r + 5'h01;
            hs_r[cnt_r] <= blk[1];
            crc_r       <= (cnt_r == 5'h1F) ? 12'h000 : crc_nxt;
            prv_r       <= (cnt_r == 5'h1F) ? crc_nxt : prv_r;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    property p_hdr; vld |-> blk[0] != blk[1]; endproperty
    a_hdr: assert property (p_hdr) else $error("sync bits equal");
    property p_mb_tail; vld && cnt_r > 5'h1A |-> blk[1] == (cnt_r == 5'h1F);
    endproperty
    a_mb_tail: assert property (p_mb_tail) else $error("bad end pattern");
    property p_ext_end; vld && cnt_r == 5'h16 |-> blk[1]; endproperty
    a_ext_end: assert property (p_ext_end) else $error("end flag low");
    property p_ones;
        vld && cnt_r inside {5'h03, 5'h07, 5'h0B, 5'h0F, 5'h13, 5'h15, 5'h17}
        |-> blk[1];
    endproperty
    a_ones: assert property (p_ones) else $error("fixed one low");
    property p_cmd;
        vld && cnt_r inside {5'h10, 5'h11, 5'h12, 5'h14, 5'h18, 5'h19, 5'h1A}
        |-> !blk[1];
    endproperty
    a_cmd: assert property (p_cmd) else $error("command bit set");
    property p_crc; vld && cnt_r == 5'h0F |-> got_crc == prv_r; endproperty
    a_crc: assert property (p_crc) else $error("parity wrong");
    property p_gap; $fell(vld) && !$past(srst_in) |=> vld; endproperty
    a_gap: assert property (p_gap) else $error("gap not one cycle");
    property p_run; $rose(vld) |-> vld [*8]; endproperty
    a_run: assert property (p_run) else $error("blocks not back to back");
    c_restart: cover property ($fell(vld));
    c_mb_end: cover property (vld && cnt_r == 5'h1F);
    c_crc: cover property (vld && cnt_r == 5'h0F && prv_r != 12'h000);
endmodule

// file: src/lbf_link_if.sv
`timescale 1ns/10ps
interface lbf_link_if;
    logic [lbf_pkg::BLK_W-1:0] blk;
    logic                      vld;

    modport tx (
        output blk,
        output vld
    );

    modport rx (
        input  blk,
        input  vld
    );
endinterface

// file: src/lbf_pkg.sv
package lbf_pkg;

    // Block geometry
    localparam int unsigned DATA_W    = 64;
    localparam int unsigned BLK_W     = 66;
    localparam int unsigned OCT_W     = 8;
    localparam int unsigned HDR_LO    = 0;
    localparam int unsigned HDR_HI    = 1;
    localparam int unsigned DATA_LO   = 2;

    // Multiblock geometry; one multiblock per extended multiblock
    localparam int unsigned MB_BLOCKS = 32;
    localparam int unsigned E_MB      = 1;
    localparam int unsigned IDX_W     = 5;
    localparam logic [IDX_W-1:0] IDX_FIRST = 5'h00;
    localparam logic [IDX_W-1:0] IDX_LAST  = 5'h1F;

    // Sync header stream layout, parity mode
    localparam int unsigned STREAM_W   = 32;
    localparam int unsigned EXT_END_BIT = 22;
    localparam int unsigned CRC_SPAN   = 15;
    localparam int unsigned CRC_GROUP  = 4;
    localparam logic [STREAM_W-1:0] STREAM_ONES     = 32'h80A8_8888;
    localparam logic [STREAM_W-1:0] STREAM_CRC_MASK = 32'h0000_7777;
    localparam logic [STREAM_W-1:0] EXT_END_MASK    = 32'h0040_0000;
    // Pilot: fixed ones, end-of-multiblock tail, end flag always set
    localparam logic [STREAM_W-1:0] PILOT_EXP = STREAM_ONES | EXT_END_MASK;

    // Parity generator, polynomial in Koopman (implicit +1) notation
    localparam int unsigned CRC_W = 12;
    localparam logic [CRC_W-1:0] CRC_POLY_KOOP = 12'h987;
    localparam logic [CRC_W-1:0] CRC_TAPS = {CRC_POLY_KOOP[10:0], 1'b1};
    localparam logic [CRC_W-1:0] CRC_INIT = 12'h000;

    typedef enum logic {
        LBF_IDLE = 1'b0,
        LBF_RUN  = 1'b1
    } lbf_state_t;

    // Serial parity over one block payload, bit 0 first
    function automatic logic [CRC_W-1:0] lbf_crc64(
        input logic [CRC_W-1:0]  crc,
        input logic [DATA_W-1:0] d
    );
        logic [CRC_W-1:0] c;
        logic             fb;
        c = crc;
        for (int i = 0; i < DATA_W; i++) begin
            fb = c[CRC_W-1] ^ d[i];
            c = {c[CRC_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ CRC_TAPS;
            end
        end
        return c;
    endfunction

    // Stream position p carries parity bit 11 - (p - p/4)
    function automatic logic [CRC_W-1:0] lbf_stream_crc(
        input logic [STREAM_W-1:0] s
    );
        logic [CRC_W-1:0] c;
        c = CRC_INIT;
        for (int p = 0; p < CRC_SPAN; p++) begin
            if ((p % CRC_GROUP) != (CRC_GROUP - 1)) begin
                c[CRC_W - 1 - (p - p / CRC_GROUP)] = s[p];
            end
        end
        return c;
    endfunction

endpackage

// file: src/lbf_rx_deframer.sv
`timescale 1ns/10ps
module lbf_rx_deframer
    import lbf_pkg::*;
(
    input  wire logic                        core_clk_in,
    input  wire logic                        srst_in,
    input  wire logic                        sysref_in,
    lbf_link_if.rx                           link,
    output logic [lbf_pkg::DATA_W-1:0]       data_out,
    output logic                             data_vld_out,
    output logic                             emb_clk_out,
    output logic                             hdr_err_out,
    output logic                             pilot_err_out,
    output logic                             crc_err_out
);
    import lbf_pkg::*;

    typedef struct packed {
        lbf_state_t           st;
        logic                 sysref_d;
        logic [IDX_W-1:0]     idx;
        logic [STREAM_W-1:0]  stream;
        logic [CRC_W-1:0]     crc_run;
        logic [CRC_W-1:0]     crc_prev;
        logic                 crc_prev_ok;
        logic [DATA_W-1:0]    data;
        logic                 data_vld;
        logic                 emb_tick;
        logic                 hdr_err;
        logic                 pilot_err;
        logic                 crc_err;
    } lbf_rx_regs_t;

    lbf_rx_regs_t         rx_r;
    lbf_rx_regs_t         rx_nxt;
    logic                 sync_edge;
    logic                 on_phase;
    logic                 first_blk;
    logic [STREAM_W-1:0]  s;
    logic [CRC_W-1:0]     c;

    always_comb begin
        rx_nxt = rx_r;
        rx_nxt.sysref_d = sysref_in;
        rx_nxt.data_vld = 1'b0;
        rx_nxt.emb_tick = 1'b0;
        rx_nxt.hdr_err = 1'b0;
        rx_nxt.pilot_err = 1'b0;
        rx_nxt.crc_err = 1'b0;

        sync_edge = sysref_in & ~rx_r.sysref_d;
        // Receive trails transmit by one block, so in phase is block 30 here
        on_phase = (rx_r.st == LBF_RUN) &&
                   (rx_r.idx == IDX_W'(IDX_LAST - 1'b1));
        first_blk = (rx_r.idx == IDX_FIRST);
        s = first_blk ? '0 : rx_r.stream;
        s[rx_r.idx] = link.blk[HDR_HI];
        c = lbf_crc64(first_blk ? CRC_INIT : rx_r.crc_run,
                      link.blk[BLK_W-1:DATA_LO]);

        if (sync_edge && !on_phase) begin
            // Old parity belongs to a different phase, so drop it
            rx_nxt.st = LBF_RUN;
            rx_nxt.idx = IDX_FIRST;
            rx_nxt.crc_prev_ok = 1'b0;
        end else if (rx_r.st == LBF_RUN && link.vld) begin
            rx_nxt.hdr_err = ~(link.blk[HDR_HI] ^ link.blk[HDR_LO]);
            rx_nxt.data = link.blk[BLK_W-1:DATA_LO];
            rx_nxt.data_vld = 1'b1;
            rx_nxt.emb_tick = first_blk;
            rx_nxt.stream = s;
            rx_nxt.crc_run = c;
            rx_nxt.idx = IDX_W'(rx_r.idx + 1'b1);
            if (rx_r.idx == IDX_LAST) begin
                rx_nxt.pilot_err = (s & ~STREAM_CRC_MASK) != PILOT_EXP;
                rx_nxt.crc_err = rx_r.crc_prev_ok &&
                    (lbf_stream_crc(s) != rx_r.crc_prev);
                rx_nxt.crc_prev = c;
                rx_nxt.crc_prev_ok = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rx_r <= '0;
        end else begin
            rx_r <= rx_nxt;
        end
    end

    assign data_out      = rx_r.data;
    assign data_vld_out  = rx_r.data_vld;
    assign emb_clk_out   = rx_r.emb_tick;
    assign hdr_err_out   = rx_r.hdr_err;
    assign pilot_err_out = rx_r.pilot_err;
    assign crc_err_out   = rx_r.crc_err;

endmodule

// file: src/lbf_tx_framer.sv
`timescale 1ns/10ps
module lbf_tx_framer
    import lbf_pkg::*;
(
    input  wire logic                        core_clk_in,
    input  wire logic                        srst_in,
    input  wire logic                        sysref_in,
    input  wire logic [lbf_pkg::DATA_W-1:0]  data_in,
    input  wire logic                        data_vld_in,
    output logic                             run_out,
    output logic                             emb_clk_out,
    output logic                             underrun_out,
    output logic                             sysref_slip_out,
    lbf_link_if.tx                           link
);
    import lbf_pkg::*;

    typedef struct packed {
        lbf_state_t           st;
        logic                 sysref_d;
        logic [IDX_W-1:0]     idx;
        logic [CRC_W-1:0]     crc_run;
        logic [STREAM_W-1:0]  stream;
        logic [BLK_W-1:0]     blk;
        logic                 blk_vld;
        logic                 emb_tick;
        logic                 underrun;
        logic                 slip;
    } lbf_tx_regs_t;

    lbf_tx_regs_t         tx_r;
    lbf_tx_regs_t         tx_nxt;
    logic                 sync_edge;
    logic                 on_phase;
    logic                 first_blk;
    logic                 hdr_bit;
    logic [STREAM_W-1:0]  cur_stream;
    logic [DATA_W-1:0]    payload;
    logic [CRC_W-1:0]     crc_seed;

    // Stream for one multiblock from the parity of the previous one
    function automatic logic [STREAM_W-1:0] lbf_stream_build(
        input logic [CRC_W-1:0] crc
    );
        logic [STREAM_W-1:0] s;
        // Fixed ones, zero command word, end flag and 00001 tail
        s = PILOT_EXP;
        for (int p = 0; p < CRC_SPAN; p++) begin
            if ((p % CRC_GROUP) != (CRC_GROUP - 1)) begin
                s[p] = crc[CRC_W - 1 - (p - p / CRC_GROUP)];
            end
        end
        return s;
    endfunction

    always_comb begin
        tx_nxt = tx_r;
        tx_nxt.sysref_d = sysref_in;
        tx_nxt.emb_tick = 1'b0;
        tx_nxt.underrun = 1'b0;
        tx_nxt.slip = 1'b0;

        sync_edge = sysref_in & ~tx_r.sysref_d;
        // A SYSREF landing on the last block is already in phase
        on_phase = (tx_r.st == LBF_RUN) && (tx_r.idx == IDX_LAST);
        first_blk = (tx_r.idx == IDX_FIRST);

        // Stream is latched at block 0 so it stays fixed for 32 blocks
        if (first_blk) begin
            cur_stream = lbf_stream_build(tx_r.crc_run);
        end else begin
            cur_stream = tx_r.stream;
        end
        hdr_bit = cur_stream[tx_r.idx];

        // Missing data is replaced by zeros; the lane never stalls
        payload = data_vld_in ? data_in : '0;
        crc_seed = first_blk ? CRC_INIT : tx_r.crc_run;

        if (sync_edge && !on_phase) begin
            // Restart so the next block is block 0 of a multiblock
            tx_nxt.st = LBF_RUN;
            tx_nxt.idx = IDX_FIRST;
            tx_nxt.crc_run = CRC_INIT;
            tx_nxt.blk_vld = 1'b0;
            tx_nxt.slip = (tx_r.st == LBF_RUN);
        end else if (tx_r.st == LBF_RUN) begin
            // Header occupies bits 1:0, octet k at [8k+9:8k+2]
            tx_nxt.blk = {payload, hdr_bit, ~hdr_bit};
            tx_nxt.blk_vld = 1'b1;
            tx_nxt.stream = cur_stream;
            tx_nxt.crc_run = lbf_crc64(crc_seed, payload);
            // Five-bit index wraps after 32 blocks
            tx_nxt.idx = IDX_W'(tx_r.idx + 1'b1);
            // One tick per multiblock, which is one extended multiblock
            tx_nxt.emb_tick = first_blk;
            tx_nxt.underrun = ~data_vld_in;
        end else begin
            tx_nxt.blk_vld = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            tx_r <= '0;
        end else begin
            tx_r <= tx_nxt;
        end
    end

    assign run_out         = tx_r.st;
    assign emb_clk_out     = tx_r.emb_tick;
    assign underrun_out    = tx_r.underrun;
    assign sysref_slip_out = tx_r.slip;
    assign link.blk        = tx_r.blk;
    assign link.vld        = tx_r.blk_vld;

endmodule
